// ---- core/lcdhci_top.sv ----
// Display controller host command interface: pins, decoder, text memory, APB
//
// Notes on behaviour
// - Power-on defaults to 8-bit; first write full byte.
// - 4-bit mode: two accesses complete one operation.
// - Width-select function set in 8-bit runs alone.
// - After that, accesses are 4-bit transfers until a function set selects 8-bit.
// - Text memory holds 80 character codes.
// - Shift moves window only; home restores view.
// - Two-line: address jumps to line two after 40.
// - Two-line shift moves both lines, no migration.
// - On/off control enables display, cursor; screen blank.
// - Increment entry mode steps address, no shift.
// - Data write hits text memory, cursor advances, except after a CG address set.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module lcdhci_top (
  input wire logic mclk_in,                      // System clock, 200 MHz
  input wire logic srst_in,                      // Synchronous reset, high
  input wire logic psel_in,                      // APB select
  input wire logic penable_in,                   // APB enable
  input wire logic pwrite_in,                    // APB direction
  input wire logic [11:0] paddr_in,              // APB byte address
  input wire logic [31:0] pwdata_in,             // APB write data
  input wire logic [3:0] pstrb_in,               // APB byte strobes
  output logic [31:0] prdata_out,                // APB read data
  output logic pready_out,                       // APB ready
  output logic pslverr_out,                      // APB error, unmapped address
  input wire lcdhci_pkg::lcdhci_pins_t pins_in,  // Parallel pads, asynchronous
  output logic [7:0] data_line_out,              // Data pad drive value
  output logic data_line_oe_out,                 // Data pad drive enable
  input wire logic [6:0] scan_index_in,          // Drive logic character index
  output logic [7:0] scan_char_out,              // Character at scan index
  output lcdhci_pkg::lcdhci_view_t view_out      // Display state to drive logic
);
  import lcdhci_pkg::*;

  // ----------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------
  // Cursor address to linear memory index; gaps map out of range
  function automatic logic [6:0] addr_index(input logic [6:0] a, input logic two);
    logic [6:0] idx;
    idx = a;
    if (two) begin
      if (a[5:0] > LINE_COL_LAST) idx = BAD_INDEX;
      else if (a[6]) idx = 7'(LINE_LEN + {1'b0, a[5:0]});
      else idx = {1'b0, a[5:0]};
    end
    return idx;
  endfunction : addr_index

  // Step the cursor address one place up or down
  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic two,
                                           input logic up);
    logic [6:0] n;
    n = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
    if (two) begin
      if (up && a == LINE1_LAST) n = LINE2_FIRST;
      else if (up && a == LINE2_LAST) n = 7'h00;
      else if (!up && a == LINE2_FIRST) n = LINE1_LAST;
      else if (!up && a == 7'h00) n = LINE2_LAST;
    end else begin
      if (up && a == ONE_LINE_LAST) n = 7'h00;
      else if (!up && a == 7'h00) n = ONE_LINE_LAST;
    end
    return n;
  endfunction : step_addr

  // Step the window offset; both lines share one offset
  function automatic logic [6:0] step_ofs(input logic [6:0] o, input logic two,
                                          input logic left);
    logic [6:0] lim;
    lim = two ? LINE1_LAST : ONE_LINE_LAST;
    if (left) return (o >= lim) ? 7'h00 : 7'(o + 7'h01);
    return (o == 7'h00 || o > lim) ? lim : 7'(o - 7'h01);
  endfunction : step_ofs

  // ----------------------------------------------------------------
  // Pad synchronisation and strobe edges
  // ----------------------------------------------------------------
  lcdhci_pins_t pins_s;
  logic strobe_dly_q;
  logic strobe_fall;
  logic strobe_rise;

  lcdhci_sync #(.WIDTH($bits(lcdhci_pins_t))) u_sync (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .d_in(pins_in),
    .q_out(pins_s)
  );

  assign strobe_fall = strobe_dly_q & ~pins_s.strobe;
  assign strobe_rise = ~strobe_dly_q & pins_s.strobe;

  // ----------------------------------------------------------------
  // Interface state
  // ----------------------------------------------------------------
  logic four_bit_q, four_bit_d;
  logic two_line_q, two_line_d;
  logic disp_on_q, disp_on_d;
  logic cursor_q, cursor_d;
  logic blink_q, blink_d;
  logic inc_q, inc_d;
  logic shift_q, shift_d;
  logic cg_sel_q, cg_sel_d;
  logic [5:0] cg_addr_q, cg_addr_d;
  logic [6:0] ac_q, ac_d;
  logic [6:0] ofs_q, ofs_d;
  logic nib_pend_q, nib_pend_d;
  logic [3:0] nib_hi_q, nib_hi_d;
  logic [7:0] rd_byte_q, rd_byte_d;
  logic [15:0] op_count_q, op_count_d;
  logic pin_en_q, pin_en_d;
  logic [6:0] mem_index_q, mem_index_d;
  logic [31:0] prdata_q, prdata_d;
  logic err_q, err_d;
  logic [7:0] scan_q;
  lcdhci_view_t view_q;

  logic mem_we;
  logic [6:0] mem_wr_index;
  logic [7:0] mem_wr_data;
  logic [2:0][6:0] mem_rd_index;
  logic [2:0][7:0] mem_rd_data;

  lcdhci_text_mem #(.DEPTH(TEXT_DEPTH), .WIDTH(8), .READS(3)) u_text_memory (
    .mclk_in(mclk_in),
    .wr_en_in(mem_we),
    .wr_index_in(mem_wr_index),
    .wr_data_in(mem_wr_data),
    .rd_index_in(mem_rd_index),
    .rd_data_out(mem_rd_data)
  );

  assign mem_rd_index[0] = addr_index(ac_q, two_line_q);
  assign mem_rd_index[1] = mem_index_q;
  assign mem_rd_index[2] = scan_index_in;

  // ----------------------------------------------------------------
  // Pin transfers: nibble pairing and instruction execution
  // ----------------------------------------------------------------
  // Strobes are taken on the falling edge, after data has settled
  always_comb begin
    logic [7:0] byte_v;
    logic done;
    logic take;
    byte_v = pins_s.data_line;
    done = 1'b0;
    take = strobe_fall & pin_en_q;
    four_bit_d = four_bit_q;
    two_line_d = two_line_q;
    disp_on_d = disp_on_q;
    cursor_d = cursor_q;
    blink_d = blink_q;
    inc_d = inc_q;
    shift_d = shift_q;
    cg_sel_d = cg_sel_q;
    cg_addr_d = cg_addr_q;
    ac_d = ac_q;
    ofs_d = ofs_q;
    nib_pend_d = nib_pend_q;
    nib_hi_d = nib_hi_q;
    rd_byte_d = rd_byte_q;
    op_count_d = op_count_q;
    mem_we = 1'b0;
    mem_wr_index = addr_index(ac_q, two_line_q);
    mem_wr_data = 8'h00;
    // Read byte is frozen at the first access so both nibbles match
    if (strobe_rise && pin_en_q && pins_s.read_not_write && !nib_pend_q) begin
      rd_byte_d = pins_s.register_select ? mem_rd_data[0] : {1'b0, ac_q};
    end
    if (take) begin
      if (four_bit_q && !nib_pend_q) begin
        nib_hi_d = pins_s.data_line[7:4];
        nib_pend_d = 1'b1;
      end else begin
        // In 8-bit mode the whole bus is one byte, floating low lines too
        byte_v = four_bit_q ? {nib_hi_q, pins_s.data_line[7:4]} : pins_s.data_line;
        nib_pend_d = 1'b0;
        done = 1'b1;
      end
    end
    if (done) begin
      op_count_d = 16'(op_count_q + 16'h0001);
      if (pins_s.read_not_write) begin
        if (pins_s.register_select) begin
          ac_d = step_addr(ac_q, two_line_q, inc_q);
        end
      end else if (pins_s.register_select) begin
        if (cg_sel_q) begin
          cg_addr_d = inc_q ? 6'(cg_addr_q + 6'h01) : 6'(cg_addr_q - 6'h01);
        end else begin
          mem_we = 1'b1;
          mem_wr_data = byte_v;
          ac_d = step_addr(ac_q, two_line_q, inc_q);
          if (shift_q) ofs_d = step_ofs(ofs_q, two_line_q, inc_q);
        end
      end else if (byte_v[BIT_SET_ADDR]) begin
        ac_d = byte_v[6:0];
        cg_sel_d = 1'b0;
      end else if (byte_v[BIT_SET_CG]) begin
        cg_addr_d = byte_v[5:0];
        cg_sel_d = 1'b1;
      end else if (byte_v[BIT_FUNC]) begin
        four_bit_d = ~byte_v[BIT_FUNC_WIDTH8];
        two_line_d = byte_v[BIT_FUNC_TWO_LINE];
        // A one-line offset past a line would leave the window off both lines
        if (byte_v[BIT_FUNC_TWO_LINE] && ofs_q > LINE1_LAST) ofs_d = 7'h00;
      end else if (byte_v[BIT_SHIFT_CMD]) begin
        if (byte_v[BIT_SHIFT_DISP]) begin
          ofs_d = step_ofs(ofs_q, two_line_q, ~byte_v[BIT_SHIFT_RIGHT]);
        end else begin
          ac_d = step_addr(ac_q, two_line_q, byte_v[BIT_SHIFT_RIGHT]);
        end
      end else if (byte_v[BIT_ONOFF]) begin
        disp_on_d = byte_v[BIT_DISP_ON];
        cursor_d = byte_v[BIT_CURSOR_ON];
        blink_d = byte_v[BIT_BLINK_ON];
      end else if (byte_v[BIT_ENTRY]) begin
        inc_d = byte_v[BIT_ENTRY_INC];
        shift_d = byte_v[BIT_ENTRY_SHIFT];
      end else if (byte_v[BIT_HOME]) begin
        // Memory is left alone, so the first text comes back into view
        ac_d = 7'h00;
        ofs_d = 7'h00;
        cg_sel_d = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave: zero wait, read data captured in the setup cycle
  // ----------------------------------------------------------------
  always_comb begin
    logic setup;
    logic wr;
    setup = psel_in & ~penable_in;
    wr = psel_in & penable_in & pwrite_in;
    pin_en_d = pin_en_q;
    mem_index_d = mem_index_q;
    prdata_d = prdata_q;
    err_d = err_q;
    if (setup) begin
      err_d = 1'b0;
      prdata_d = 32'h0000_0000;
      unique case (paddr_in)
        ADDR_CTRL: prdata_d = {31'h0, pin_en_q};
        ADDR_STATUS: prdata_d = {8'h00, cg_sel_q, ofs_q, 1'b0, ac_q, nib_pend_q,
                                 shift_q, inc_q, blink_q, cursor_q, disp_on_q,
                                 two_line_q, four_bit_q};
        ADDR_MEM_INDEX: prdata_d = {25'h0, mem_index_q};
        ADDR_MEM_DATA: prdata_d = {24'h0, mem_rd_data[1]};
        ADDR_OP_COUNT: prdata_d = {16'h0, op_count_q};
        default: err_d = 1'b1;
      endcase
    end
    if (wr && pstrb_in[0] && paddr_in == ADDR_CTRL) pin_en_d = pwdata_in[0];
    if (wr && pstrb_in[0] && paddr_in == ADDR_MEM_INDEX) mem_index_d = pwdata_in[6:0];
  end

  assign prdata_out = prdata_q;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & err_q;

  // ----------------------------------------------------------------
  // Pad drive: only while a read strobe is high and pins are enabled
  // ----------------------------------------------------------------
  assign data_line_oe_out = pin_en_q & pins_s.strobe & pins_s.read_not_write;
  assign data_line_out = !four_bit_q ? rd_byte_q :
                         (nib_pend_q ? {rd_byte_q[3:0], 4'h0} : {rd_byte_q[7:4], 4'h0});

  assign scan_char_out = scan_q;
  assign view_out = view_q;

  // ----------------------------------------------------------------
  // State registers; reset gives 8-bit, one line, display off
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      strobe_dly_q <= 1'b0;
      four_bit_q <= 1'b0;
      two_line_q <= 1'b0;
      disp_on_q <= 1'b0;
      cursor_q <= 1'b0;
      blink_q <= 1'b0;
      inc_q <= INC_RESET;
      shift_q <= 1'b0;
      cg_sel_q <= 1'b0;
      cg_addr_q <= 6'h00;
      ac_q <= 7'h00;
      ofs_q <= 7'h00;
      nib_pend_q <= 1'b0;
      nib_hi_q <= 4'h0;
      rd_byte_q <= 8'h00;
      op_count_q <= 16'h0000;
      pin_en_q <= CTRL_PIN_EN_RESET;
      mem_index_q <= 7'h00;
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
      scan_q <= 8'h00;
      view_q <= '0;
    end else begin
      strobe_dly_q <= pins_s.strobe;
      four_bit_q <= four_bit_d;
      two_line_q <= two_line_d;
      disp_on_q <= disp_on_d;
      cursor_q <= cursor_d;
      blink_q <= blink_d;
      inc_q <= inc_d;
      shift_q <= shift_d;
      cg_sel_q <= cg_sel_d;
      cg_addr_q <= cg_addr_d;
      ac_q <= ac_d;
      ofs_q <= ofs_d;
      nib_pend_q <= nib_pend_d;
      nib_hi_q <= nib_hi_d;
      rd_byte_q <= rd_byte_d;
      op_count_q <= op_count_d;
      pin_en_q <= pin_en_d;
      mem_index_q <= mem_index_d;
      prdata_q <= prdata_d;
      err_q <= err_d;
      scan_q <= mem_rd_data[2];
      view_q <= '{display_on: disp_on_q, cursor_on: cursor_q, blink_on: blink_q,
                  two_line: two_line_q, window_offset: ofs_q,
                  cursor_index: addr_index(ac_q, two_line_q)};
    end
  end

endmodule : lcdhci_top

// ---- core/lcdhci_pkg.sv ----
// Shared constants, types and register map of the display command interface
package lcdhci_pkg;

  // ----------------------------------------------------------------
  // Text memory geometry and address map
  // ----------------------------------------------------------------
  localparam int TEXT_DEPTH = 80;
  localparam logic [6:0] ONE_LINE_LAST = 7'h4F;
  localparam logic [6:0] LINE1_LAST = 7'h27;
  localparam logic [6:0] LINE2_FIRST = 7'h40;
  localparam logic [6:0] LINE2_LAST = 7'h67;
  localparam logic [6:0] LINE_LEN = 7'h28;
  localparam logic [5:0] LINE_COL_LAST = 6'h27;
  localparam logic [6:0] BAD_INDEX = 7'h7F;

  // ----------------------------------------------------------------
  // Instruction field positions
  // ----------------------------------------------------------------
  localparam int BIT_SET_ADDR = 7;
  localparam int BIT_SET_CG = 6;
  localparam int BIT_FUNC = 5;
  localparam int BIT_SHIFT_CMD = 4;
  localparam int BIT_ONOFF = 3;
  localparam int BIT_ENTRY = 2;
  localparam int BIT_HOME = 1;
  localparam int BIT_FUNC_WIDTH8 = 4;
  localparam int BIT_FUNC_TWO_LINE = 2;
  localparam int BIT_DISP_ON = 2;
  localparam int BIT_CURSOR_ON = 1;
  localparam int BIT_BLINK_ON = 0;
  localparam int BIT_ENTRY_INC = 1;
  localparam int BIT_ENTRY_SHIFT = 0;
  localparam int BIT_SHIFT_DISP = 3;
  localparam int BIT_SHIFT_RIGHT = 2;

  // ----------------------------------------------------------------
  // APB register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_MEM_INDEX = 12'h008;
  localparam logic [11:0] ADDR_MEM_DATA = 12'h00C;
  localparam logic [11:0] ADDR_OP_COUNT = 12'h010;
  localparam logic CTRL_PIN_EN_RESET = 1'b1;
  localparam logic INC_RESET = 1'b1;

  // Parallel pin bundle as seen on the pads
  typedef struct packed {
    logic strobe;
    logic register_select;
    logic read_not_write;
    logic [7:0] data_line;
  } lcdhci_pins_t;

  // Display state handed to the drive logic
  typedef struct packed {
    logic display_on;
    logic cursor_on;
    logic blink_on;
    logic two_line;
    logic [6:0] window_offset;
    logic [6:0] cursor_index;
  } lcdhci_view_t;

endpackage : lcdhci_pkg

// ---- core/lcdhci_sync.sv ----
// Two flip-flop synchroniser for a bundle of pad inputs
`timescale 1ns/1ps
module lcdhci_sync #(
  parameter int WIDTH = 11
) (
  input wire logic mclk_in,             // System clock
  input wire logic srst_in,             // Synchronous reset, high
  input wire logic [WIDTH-1:0] d_in,    // Asynchronous pad levels
  output logic [WIDTH-1:0] q_out        // Levels in the clock domain
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // ----------------------------------------------------------------
  // Two stages; only the second stage leaves this module
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;

endmodule : lcdhci_sync

// ---- core/lcdhci_text_mem.sv ----
// Character code store with one write port and several read ports
`timescale 1ns/1ps
module lcdhci_text_mem #(
  parameter int DEPTH = 80,
  parameter int WIDTH = 8,
  parameter int READS = 3
) (
  input wire logic mclk_in,                       // System clock
  input wire logic wr_en_in,                      // Write strobe
  input wire logic [6:0] wr_index_in,             // Write index
  input wire logic [WIDTH-1:0] wr_data_in,        // Write data
  input wire logic [READS-1:0][6:0] rd_index_in,  // Read indices
  output logic [READS-1:0][WIDTH-1:0] rd_data_out // Read data, zero if out of range
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // Write port; indices past the end are dropped, not wrapped
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (wr_en_in && (int'(wr_index_in) < DEPTH)) begin
      mem[wr_index_in] <= wr_data_in;
    end
  end

  // ----------------------------------------------------------------
  // Read ports
  // ----------------------------------------------------------------
  for (genvar i = 0; i < READS; i++) begin : g_rd
    assign rd_data_out[i] = (int'(rd_index_in[i]) < DEPTH) ? mem[rd_index_in[i]] : '0;
  end

endmodule : lcdhci_text_mem

// ---- bench/lcdhci_checker.sv ----
// Port-level assertion checker for the display command interface
`timescale 1ns/1ps
module lcdhci_checker (
  input wire logic mclk_in,                      // System clock
  input wire logic srst_in,                      // Synchronous reset, high
  input wire lcdhci_pkg::lcdhci_pins_t pins_in,  // Pad levels
  input wire logic data_line_oe_out,             // Pad drive enable
  input wire logic [6:0] scan_index_in,          // Scan index
  input wire logic [7:0] scan_char_out,          // Scan character
  input wire lcdhci_pkg::lcdhci_view_t view_out  // Display state
);
  import lcdhci_pkg::*;
  logic stb_q;
  logic stb_d;
  logic [3:0] since_q;
  logic [3:0] since_d;
  // ------------------------------------------------------------
  // Cycles since the last strobe fall
  // ------------------------------------------------------------
  // Saturates, so a long idle span never wraps back into the window
  always_comb begin
    stb_d = pins_in.strobe;
    since_d = (since_q == 4'hF) ? since_q : since_q + 4'h1;
    if (stb_q && !pins_in.strobe) begin
      since_d = 4'h0;
    end
    if (srst_in) begin
      since_d = 4'hF;
    end
  end
  always_ff @(posedge mclk_in) begin
    stb_q <= stb_d;
    since_q <= since_d;
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_RESET_VIEW: assert property (@(posedge mclk_in) disable iff (srst_in)
    $fell(srst_in) |-> view_out == '0) else $error("view not clear after reset");
  AST_VIEW_AFTER_FALL: assert property (@(posedge mclk_in) disable iff (srst_in)
    $changed(view_out) |-> since_q inside {[4'h1:4'h9]})
    else $error("view changed without a strobe fall");
  AST_OE_STROBE: assert property (@(posedge mclk_in) disable iff (srst_in)
    data_line_oe_out |-> $past(pins_in.strobe, 1) || $past(pins_in.strobe, 2)
    || $past(pins_in.strobe, 3)) else $error("pad drive without strobe");
  AST_OE_READ: assert property (@(posedge mclk_in) disable iff (srst_in)
    data_line_oe_out |-> $past(pins_in.read_not_write, 2)
    || $past(pins_in.read_not_write, 3)) else $error("pad drive on a write");
  AST_SCAN_RANGE: assert property (@(posedge mclk_in) disable iff (srst_in)
    scan_index_in >= TEXT_DEPTH |=> scan_char_out == 8'h00)
    else $error("scan beyond memory not zero");
  AST_OFFSET_RANGE: assert property (@(posedge mclk_in) disable iff (srst_in)
    view_out.window_offset <= ONE_LINE_LAST) else $error("window offset too large");
  AST_OFFSET_TWO: assert property (@(posedge mclk_in) disable iff (srst_in)
    view_out.two_line |-> view_out.window_offset <= LINE_COL_LAST)
    else $error("two-line offset beyond line length");
  AST_CURSOR_ONE: assert property (@(posedge mclk_in) disable iff (srst_in)
    !view_out.two_line |-> view_out.cursor_index <= ONE_LINE_LAST)
    else $error("one-line cursor beyond memory");
endmodule : lcdhci_checker

bind lcdhci_top lcdhci_checker chk_u (
  .mclk_in(mclk_in), .srst_in(srst_in), .pins_in(pins_in),
  .data_line_oe_out(data_line_oe_out), .scan_index_in(scan_index_in),
  .scan_char_out(scan_char_out), .view_out(view_out)
);

// ---- bench/lcdhci_host_model.sv ----
// Host processor model driving the parallel pads
`timescale 1ns/1ps
module lcdhci_host_model (
  input wire logic mclk_in,                     // System clock
  input wire logic [7:0] data_line_in,          // Device pad drive value
  input wire logic data_line_oe_in,             // Device pad drive enable
  output lcdhci_pkg::lcdhci_pins_t pins_out     // Resolved pad levels
);
  import lcdhci_pkg::*;
  logic stb = 1'b0;
  logic rs = 1'b0;
  logic rw = 1'b0;
  logic hi_en = 1'b0;
  logic lo_en = 1'b0;
  logic [7:0] drv = 8'h00;
  logic [7:0] last = 8'h00;
  // Wire level; an undriven line toggles so stale data cannot pass
  always_comb begin
    pins_out.strobe = stb;
    pins_out.register_select = rs;
    pins_out.read_not_write = rw;
    pins_out.data_line[7:4] = data_line_oe_in ? data_line_in[7:4] : hi_en ? drv[7:4] : ~last[7:4];
    pins_out.data_line[3:0] = data_line_oe_in ? data_line_in[3:0] : lo_en ? drv[3:0] : ~last[3:0];
  end
  always @(posedge mclk_in) begin
    last <= pins_out.data_line;
  end
  // One strobe cycle, lines held well past the two-flop sampling delay
  task automatic access(input logic s, input logic w, input logic [7:0] b,
                        input logic open_lo, output logic [7:0] got);
    @(posedge mclk_in);
    rs <= s;
    rw <= w;
    drv <= b;
    hi_en <= !w;
    lo_en <= !w && !open_lo;
    repeat (4) @(posedge mclk_in);
    stb <= 1'b1;
    repeat (6) @(posedge mclk_in);
    got = pins_out.data_line;
    stb <= 1'b0;
    repeat (5) @(posedge mclk_in);
    hi_en <= 1'b0;
    lo_en <= 1'b0;
  endtask : access
  // Whole byte in 8-bit mode, upper then lower nibble otherwise
  // Bare bytes on the pads; no control byte is prefixed
  task automatic send(input logic s, input logic w, input logic [7:0] b,
                      input logic four, output logic [7:0] got);
    logic [7:0] hi;
    logic [7:0] lo;
    if (four) begin
      access(s, w, {b[7:4], 4'h0}, 1'b1, hi);
      access(s, w, {b[3:0], 4'h0}, 1'b1, lo);
      got = {hi[7:4], lo[7:4]};
    end else begin
      access(s, w, b, 1'b0, got);
    end
  endtask : send
endmodule : lcdhci_host_model

// ---- bench/testbench.sv ----
// Self-checking bench for the display command interface
`timescale 1ns/1ps
module testbench;
  import lcdhci_pkg::*;
  logic mclk_in;
  logic srst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [3:0] pstrb_in = 4'hF;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  lcdhci_pins_t pins_in;
  logic [7:0] data_line_out;
  logic data_line_oe_out;
  logic [6:0] scan_index_in = 7'h00;
  logic [7:0] scan_char_out;
  lcdhci_view_t view_out;
  int n_fail = 0;
  int cmp_count = 0;
  logic fb = 1'b0;
  logic [7:0] rd8;
  logic [31:0] rd32;
  logic err;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;

  lcdhci_top dut_u (.mclk_in(mclk_in), .srst_in(srst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .pins_in(pins_in),
    .data_line_out(data_line_out), .data_line_oe_out(data_line_oe_out),
    .scan_index_in(scan_index_in), .scan_char_out(scan_char_out), .view_out(view_out));
  lcdhci_host_model host_u (.mclk_in(mclk_in), .data_line_in(data_line_out),
    .data_line_oe_in(data_line_oe_out), .pins_out(pins_in));

  // ------------------------------------------------------------
  // Clock, watchdog and verdict
  // ------------------------------------------------------------
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  // Tests need about 530 cycles; nearly forty times that means a hang
  initial begin
    repeat (20000) @(posedge mclk_in);
    n_fail++;
    $display("watchdog expired");
    summarize();
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // ------------------------------------------------------------
  // Compare and access tasks
  // ------------------------------------------------------------
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8
  // Setup, then access held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    @(posedge mclk_in);
    while (pready_out !== 1'b1) begin
      @(posedge mclk_in);
    end
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd32, err);
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd32, err);
    chk32(rd32 & m, e);
  endtask : rchk
  task automatic cmd(input logic [7:0] b);
    host_u.send(1'b0, 1'b0, b, fb, rd8);
  endtask : cmd
  task automatic dat(input logic [7:0] b);
    host_u.send(1'b1, 1'b0, b, fb, rd8);
  endtask : dat

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge mclk_in);
    srst_in <= 1'b0;
    rchk(ADDR_STATUS, ALL, 32'h20);
    rchk(ADDR_CTRL, ALL, 32'h1);
    apb(1'b0, 12'h020, 32'h0, rd32, err);
    chk32({31'h0, err}, 32'h1);
    $display("test reset done");
    host_u.access(1'b0, 1'b0, 8'h20, 1'b1, rd8);
    rchk(ADDR_STATUS, 32'h81, 32'h01);
    fb = 1'b1;
    cmd(8'h20);
    rchk(ADDR_STATUS, ALL, 32'h21);
    cmd(8'h0E);
    rchk(ADDR_STATUS, ALL, 32'h2D);
    chk32({31'h0, view_out.display_on}, 32'h1);
    cmd(8'h06);
    wr(ADDR_MEM_INDEX, 32'h0);
    host_u.access(1'b1, 1'b0, 8'h50, 1'b1, rd8);
    rchk(ADDR_STATUS, 32'h80, 32'h80);
    host_u.access(1'b1, 1'b0, 8'h00, 1'b1, rd8);
    rchk(ADDR_STATUS, ALL, 32'h12D);
    rchk(ADDR_MEM_DATA, ALL, 32'h50);
    cmd(8'h80);
    host_u.send(1'b1, 1'b1, 8'h00, fb, rd8);
    chk8(rd8, 8'h50);
    $display("test four_bit done");
    cmd(8'h34);
    fb = 1'b0;
    rchk(ADDR_STATUS, ALL, 32'h12E);
    cmd(8'hA7);
    dat(8'h41);
    rchk(ADDR_STATUS, 32'h7F00, 32'h4000);
    wr(ADDR_MEM_INDEX, 32'd39);
    rchk(ADDR_MEM_DATA, ALL, 32'h41);
    $display("test two_line done");
    cmd(8'h18);
    cmd(8'h18);
    cmd(8'h1C);
    rchk(ADDR_STATUS, 32'h7F0000, 32'h10000);
    chk32({25'h0, view_out.window_offset}, 32'h1);
    rchk(ADDR_MEM_DATA, ALL, 32'h41);
    cmd(8'h02);
    rchk(ADDR_STATUS, 32'h7F7F00, 32'h0);
    $display("test shift done");
    wr(ADDR_CTRL, 32'h0);
    dat(8'h55);
    rchk(ADDR_STATUS, 32'h7F00, 32'h0);
    wr(ADDR_CTRL, 32'h1);
    cmd(8'h07);
    dat(8'h4D);
    rchk(ADDR_STATUS, 32'h7F7F40, 32'h10140);
    cmd(8'h30);
    cmd(8'hCF);
    dat(8'h5A);
    rchk(ADDR_STATUS, 32'h7F02, 32'h0);
    rchk(ADDR_OP_COUNT, ALL, 32'd19);
    wr(ADDR_MEM_INDEX, 32'd79);
    rchk(ADDR_MEM_DATA, ALL, 32'h5A);
    wr(ADDR_MEM_INDEX, 32'd80);
    rchk(ADDR_MEM_DATA, ALL, 32'h0);
    @(posedge mclk_in);
    scan_index_in <= 7'd79;
    repeat (3) @(posedge mclk_in);
    chk8(scan_char_out, 8'h5A);
    scan_index_in <= 7'd80;
    repeat (3) @(posedge mclk_in);
    chk8(scan_char_out, 8'h00);
    $display("test capacity done");
    summarize();
  end
endmodule : testbench
